// ===== shared/scg_pkg.sv
// Constants shared by the system clock generator and its clock quality checker.
// Assumes one 200 MHz clock (aclk) with every slower clock carried as an enable pulse.
`default_nettype none
package scg_pkg;
  // Main clock (aclk) period in picoseconds.
  localparam int CLK_PERIOD_PS = 5000;
  // Oscillator is declared lost after this long without a rising edge.
  localparam int LOSS_TIME_NS  = 2000;
  localparam int LOSS_CYCLES   = (LOSS_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Oscillator periods shorter than this cannot be sampled cleanly.
  localparam int MIN_PERIOD_CYCLES = 4;

  localparam int MULT_W   = 6;
  localparam int REFDIV_W = 4;
  localparam int PERIOD_W = 16;

  localparam logic [11:0] ADDR_MULT   = 12'h000;
  localparam logic [11:0] ADDR_REFDIV = 12'h004;
  localparam logic [11:0] ADDR_CTRL   = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00c;
  localparam logic [11:0] ADDR_PERIOD = 12'h010;

  localparam int CTRL_SYNTH_SEL = 0;
  localparam int CTRL_SYNTH_ON  = 1;
  localparam int ST_ACTIVE_SRC  = 0;
  localparam int ST_MON_LOSS    = 1;
  localparam int ST_Q_LOST      = 2;
  localparam int ST_Q_UNUSABLE  = 3;
  localparam int ST_OSC_TYPE    = 4;
  localparam int ST_PENDING     = 5;

  localparam logic [5:0] MULT_RST      = 6'h00;
  localparam logic [3:0] REFDIV_RST    = 4'h0;
  localparam logic       SYNTH_SEL_RST = 1'h0;
  localparam logic       SYNTH_ON_RST  = 1'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SW_RUN   = 3'h1,
    SW_ALIGN = 3'h2,
    SW_SPARE = 3'h4
  } scg_sw_state_t;
endpackage : scg_pkg
`default_nettype wire

// ===== logic/scg_quality_checker.sv
// Clock quality checker: measures the raw oscillator period and flags loss or misuse.
// Assumes osc_edge is a one-cycle pulse at each rising edge of the oscillator.
`default_nettype none
module scg_quality_checker #(
  parameter int PERIOD_W = scg_pkg::PERIOD_W
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                osc_edge,
  output var  logic [PERIOD_W-1:0] period,
  output var  logic                lost,
  output var  logic                unusable
);
  localparam logic [PERIOD_W-1:0] LOSS_CNT = PERIOD_W'(scg_pkg::LOSS_CYCLES);
  localparam logic [PERIOD_W-1:0] MIN_CNT  = PERIOD_W'(scg_pkg::MIN_PERIOD_CYCLES);

  logic [PERIOD_W-1:0] cnt;
  logic [PERIOD_W-1:0] next_cnt;
  logic [PERIOD_W-1:0] next_period;
  logic                next_lost;
  logic                next_unusable;
  logic [PERIOD_W-1:0] cnt_inc;

  always_comb begin
    cnt_inc       = (cnt == '1) ? cnt : cnt + PERIOD_W'(1);
    next_cnt      = cnt_inc;
    next_period   = period;
    next_unusable = unusable;
    next_lost     = lost;
    if (osc_edge) begin
      next_cnt      = '0;
      next_period   = cnt_inc;
      next_unusable = (cnt_inc < MIN_CNT);
      next_lost     = 1'b0;
    end else if (cnt_inc >= LOSS_CNT) begin
      next_lost   = 1'b1;
      next_period = '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt      <= '0;
      period   <= '0;
      lost     <= 1'b1;
      unusable <= 1'b0;
    end else begin
      cnt      <= next_cnt;
      period   <= next_period;
      lost     <= next_lost;
      unusable <= next_unusable;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_edge_clears_loss: assert property (osc_edge |=> !lost)
    else $error("Loss flag still set after an oscillator edge.");
  a_loss_after_timeout: assert property (
    (!osc_edge && cnt == LOSS_CNT - PERIOD_W'(1)) |=> lost && period == '0)
    else $error("Oscillator loss not flagged at the timeout.");
endmodule // scg_quality_checker
`default_nettype wire

// ===== logic/scg_system_clock_gen.sv
// System clock generator: source switch, synthesizer model, core, bus and oscillator ticks.
// Assumes raw_osc_clock is synchronous to aclk and that AXI4-Lite masters follow the protocol.
//
// Summary of operation
// - Bus tick on every second core tick.
// - Core ticks follow oscillator or synthesizer source.
// - Oscillator tick mirrors raw oscillator edges.
// - Monitor loss input is recorded as asserted.
// - Source switch changes only by software write.
// - Quality checker flags lost or unusable oscillator.
// - Synthesizer tick rate follows oscillator and settings.
// - Oscillator type strap sets oscillator mode.
// - Select bit set picks synthesizer, else oscillator.
// - Multiplication is two times (value plus one).
// - Reference divider divides by value plus one.
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`default_nettype none
module scg_system_clock_gen #(
  parameter int MULT_W   = scg_pkg::MULT_W,
  parameter int REFDIV_W = scg_pkg::REFDIV_W,
  parameter int PERIOD_W = scg_pkg::PERIOD_W
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        raw_osc_clock,
  input  wire logic        monitor_loss_flag,
  input  wire logic        osc_type_select,
  output var  logic        osc_mode_pierce,
  output var  logic        osc_tick,
  output var  logic        synth_tick,
  output var  logic        core_tick,
  output var  logic        bus_tick
);
  localparam int ACC_W = PERIOD_W + REFDIV_W + 1;

  // Register bank and bus handshake state.
  logic [MULT_W-1:0]   multiplier_value, next_multiplier_value;
  logic [REFDIV_W-1:0] ref_divider_value, next_ref_divider_value;
  logic                synth_select, next_synth_select;
  logic                synth_on, next_synth_on;
  logic                loss_seen, next_loss_seen;
  logic                aw_got, next_aw_got, w_got, next_w_got;
  logic [11:0]         aw_addr, next_aw_addr;
  logic [31:0]         w_data, next_w_data;
  logic [3:0]          w_strb, next_w_strb;
  logic                next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0]          next_bresp, next_rresp;
  logic [31:0]         next_rdata, rd_val, status_word;
  logic                wr_fire, rd_ok;

  // Clock path state.
  logic                osc_q, osc_seen, osc_edge;
  logic [ACC_W-1:0]    acc, next_acc, step, limit;
  logic [ACC_W:0]      acc_sum, acc_rem;
  logic                synth_fire, src_tick, active_src, next_active_src;
  logic                bus_phase, next_bus_phase, next_core_tick, next_bus_tick;
  logic                strap_done, next_strap_done, next_osc_mode_pierce;
  logic                core_since_bus, next_core_since_bus;
  scg_pkg::scg_sw_state_t sw_state, next_sw_state;
  logic [PERIOD_W-1:0] osc_period;
  logic                q_lost, q_unusable;

  scg_quality_checker #(.PERIOD_W(PERIOD_W)) u_checker (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .osc_edge (osc_edge),
    .period   (osc_period),
    .lost     (q_lost),
    .unusable (q_unusable)
  );

  always_comb begin
    status_word = '0;
    status_word[scg_pkg::ST_ACTIVE_SRC] = active_src;
    status_word[scg_pkg::ST_MON_LOSS]   = loss_seen;
    status_word[scg_pkg::ST_Q_LOST]     = q_lost;
    status_word[scg_pkg::ST_Q_UNUSABLE] = q_unusable;
    status_word[scg_pkg::ST_OSC_TYPE]   = osc_mode_pierce;
    status_word[scg_pkg::ST_PENDING]    = (synth_select != active_src) ||
                                          (sw_state != scg_pkg::SW_RUN);
    rd_ok  = 1'b1;
    rd_val = '0;
    unique case (s_axi_araddr)
      scg_pkg::ADDR_MULT:   rd_val = 32'(multiplier_value);
      scg_pkg::ADDR_REFDIV: rd_val = 32'(ref_divider_value);
      scg_pkg::ADDR_CTRL:   rd_val = 32'({synth_on, synth_select});
      scg_pkg::ADDR_STATUS: rd_val = status_word;
      scg_pkg::ADDR_PERIOD: rd_val = 32'(osc_period);
      default:              rd_ok  = 1'b0;
    endcase
  end

  always_comb begin
    next_aw_got = aw_got || (s_axi_awvalid && s_axi_awready);
    next_w_got  = w_got || (s_axi_wvalid && s_axi_wready);
    next_aw_addr = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_addr;
    next_w_data  = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : w_data;
    next_w_strb  = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : w_strb;
    next_multiplier_value  = multiplier_value;
    next_ref_divider_value = ref_divider_value;
    next_synth_select = synth_select;
    next_synth_on     = synth_on;
    next_loss_seen    = loss_seen;
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp  = s_axi_bresp;
    wr_fire = aw_got && w_got && !s_axi_bvalid;
    if (wr_fire) begin
      next_aw_got = 1'b0;
      next_w_got  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = scg_pkg::RESP_OKAY;
      if (w_strb[0]) begin
        unique case (aw_addr)
          scg_pkg::ADDR_MULT:   next_multiplier_value  = w_data[MULT_W-1:0];
          scg_pkg::ADDR_REFDIV: next_ref_divider_value = w_data[REFDIV_W-1:0];
          scg_pkg::ADDR_CTRL: begin
            next_synth_select = w_data[scg_pkg::CTRL_SYNTH_SEL];
            next_synth_on     = w_data[scg_pkg::CTRL_SYNTH_ON];
          end
          scg_pkg::ADDR_STATUS: begin
            if (w_data[scg_pkg::ST_MON_LOSS]) begin
              next_loss_seen = 1'b0;
            end
          end
          scg_pkg::ADDR_PERIOD: next_bresp = scg_pkg::RESP_OKAY;
          default:              next_bresp = scg_pkg::RESP_SLVERR;
        endcase
      end else if (aw_addr != scg_pkg::ADDR_MULT && aw_addr != scg_pkg::ADDR_REFDIV &&
                   aw_addr != scg_pkg::ADDR_CTRL && aw_addr != scg_pkg::ADDR_STATUS &&
                   aw_addr != scg_pkg::ADDR_PERIOD) begin
        next_bresp = scg_pkg::RESP_SLVERR;
      end
    end
    // A loss arriving with the clearing write stays recorded.
    if (monitor_loss_flag) begin
      next_loss_seen = 1'b1;
    end
    next_awready = !next_aw_got && !next_bvalid;
    next_wready  = !next_w_got && !next_bvalid;
    next_rvalid  = s_axi_rvalid && !s_axi_rready;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata  = rd_val;
      next_rresp  = rd_ok ? scg_pkg::RESP_OKAY : scg_pkg::RESP_SLVERR;
    end
    next_arready = !next_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      multiplier_value  <= scg_pkg::MULT_RST;
      ref_divider_value <= scg_pkg::REFDIV_RST;
      synth_select      <= scg_pkg::SYNTH_SEL_RST;
      synth_on          <= scg_pkg::SYNTH_ON_RST;
      loss_seen         <= 1'b0;
      aw_got            <= 1'b0;
      w_got             <= 1'b0;
      aw_addr           <= '0;
      w_data            <= '0;
      w_strb            <= '0;
      s_axi_awready     <= 1'b0;
      s_axi_wready      <= 1'b0;
      s_axi_bvalid      <= 1'b0;
      s_axi_bresp       <= scg_pkg::RESP_OKAY;
      s_axi_arready     <= 1'b0;
      s_axi_rvalid      <= 1'b0;
      s_axi_rdata       <= '0;
      s_axi_rresp       <= scg_pkg::RESP_OKAY;
    end else begin
      multiplier_value  <= next_multiplier_value;
      ref_divider_value <= next_ref_divider_value;
      synth_select      <= next_synth_select;
      synth_on          <= next_synth_on;
      loss_seen         <= next_loss_seen;
      aw_got            <= next_aw_got;
      w_got             <= next_w_got;
      aw_addr           <= next_aw_addr;
      w_data            <= next_w_data;
      w_strb            <= next_w_strb;
      s_axi_awready     <= next_awready;
      s_axi_wready      <= next_wready;
      s_axi_bvalid      <= next_bvalid;
      s_axi_bresp       <= next_bresp;
      s_axi_arready     <= next_arready;
      s_axi_rvalid      <= next_rvalid;
      s_axi_rdata       <= next_rdata;
      s_axi_rresp       <= next_rresp;
    end
  end

  // The synthesizer is modelled as a rate accumulator, so it tops out at one tick per aclk.
  always_comb begin
    // The first sample after reset only primes the detector, so a high pin is no false edge.
    osc_edge   = raw_osc_clock && !osc_q && osc_seen;
    step       = (ACC_W'(multiplier_value) + ACC_W'(1)) << 1;
    limit      = ACC_W'(osc_period) * (ACC_W'(ref_divider_value) + ACC_W'(1));
    acc_sum    = {1'b0, acc} + {1'b0, step};
    acc_rem    = acc_sum - {1'b0, limit};
    synth_fire = synth_on && !q_lost && (osc_period != '0) && (acc_sum >= {1'b0, limit});
    if (!synth_on || q_lost) begin
      next_acc = '0;
    end else if (synth_fire) begin
      next_acc = (acc_rem >= {1'b0, limit}) ? limit - ACC_W'(1) : acc_rem[ACC_W-1:0];
    end else begin
      next_acc = acc_sum[ACC_W-1:0];
    end
    src_tick = active_src ? synth_fire : osc_edge;
    next_sw_state   = sw_state;
    next_active_src = active_src;
    next_bus_phase  = bus_phase;
    next_core_tick  = 1'b0;
    next_bus_tick   = 1'b0;
    unique case (sw_state)
      scg_pkg::SW_RUN: begin
        if (src_tick) begin
          next_core_tick = 1'b1;
          next_bus_tick  = bus_phase;
          next_bus_phase = !bus_phase;
          // Switch only at the end of a whole bus period, then realign on the new source.
          if (bus_phase && synth_select != active_src) begin
            next_active_src = synth_select;
            next_sw_state   = scg_pkg::SW_ALIGN;
          end
        end
      end
      scg_pkg::SW_ALIGN: begin
        if (src_tick) begin
          next_sw_state = scg_pkg::SW_RUN;
        end
      end
      default: next_sw_state = scg_pkg::SW_RUN;
    endcase
    // Counts the issued ticks, so it is set exactly when the next core tick is a second one.
    next_core_since_bus  = (core_since_bus ^ core_tick) && !bus_tick;
    next_strap_done      = 1'b1;
    next_osc_mode_pierce = strap_done ? osc_mode_pierce : osc_type_select;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_q           <= 1'b0;
      osc_seen        <= 1'b0;
      acc             <= '0;
      sw_state        <= scg_pkg::SW_RUN;
      active_src      <= 1'b0;
      bus_phase       <= 1'b0;
      core_since_bus  <= 1'b0;
      strap_done      <= 1'b0;
      osc_mode_pierce <= 1'b1;
      osc_tick        <= 1'b0;
      synth_tick      <= 1'b0;
      core_tick       <= 1'b0;
      bus_tick        <= 1'b0;
    end else begin
      osc_q           <= raw_osc_clock;
      osc_seen        <= 1'b1;
      acc             <= next_acc;
      sw_state        <= next_sw_state;
      active_src      <= next_active_src;
      bus_phase       <= next_bus_phase;
      core_since_bus  <= next_core_since_bus;
      strap_done      <= next_strap_done;
      osc_mode_pierce <= next_osc_mode_pierce;
      osc_tick        <= osc_edge;
      synth_tick      <= synth_fire;
      core_tick       <= next_core_tick;
      bus_tick        <= next_bus_tick;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_switch_start;
    sw_state == scg_pkg::SW_RUN && src_tick && bus_phase && synth_select != active_src;
  endsequence
  sequence s_align_hold;
    core_tick ##1 !core_tick;
  endsequence

  a_bus_half_core: assert property (bus_tick |-> core_tick && core_since_bus)
    else $error("Bus tick not on every second core tick.");
  a_bus_follows_pair: assert property (core_tick && core_since_bus |-> bus_tick)
    else $error("Second core tick without a bus tick.");
  a_core_from_source: assert property (
    core_tick |-> $past(active_src ? synth_fire : osc_edge))
    else $error("Core tick without a tick of the active source.");
  a_osc_tick_edge: assert property (osc_edge |=> osc_tick)
    else $error("Oscillator edge not passed to the oscillator tick.");
  a_loss_recorded: assert property (monitor_loss_flag |=> status_word[scg_pkg::ST_MON_LOSS])
    else $error("Monitor loss not shown in status.");
  a_select_by_sw: assert property ($changed(synth_select) |-> $past(wr_fire))
    else $error("Source select changed without a write.");
  a_select_applied: assert property (s_switch_start |=> active_src == $past(synth_select))
    else $error("Source switch did not take the selected source.");
  a_synth_rate: assert property (
    synth_tick |-> $past(acc) + $past(step) >= $past(limit) && $past(synth_on))
    else $error("Synthesizer tick before its accumulator reached the limit.");
  a_switch_gap: assert property (s_switch_start |=> s_align_hold)
    else $error("Core tick issued while realigning to the new source.");
  a_align_no_core: assert property (sw_state == scg_pkg::SW_ALIGN |=> !core_tick)
    else $error("Core tick issued from the realign state.");
  a_strap_caught: assert property (!strap_done |=> osc_mode_pierce == $past(osc_type_select))
    else $error("Oscillator type strap not captured after reset.");
endmodule // scg_system_clock_gen
`default_nettype wire

// ===== verif/scg_osc_model.sv
// Oscillator module model: raw oscillator clock, clock monitor flag and type strap.
// Assumes the bench sets the half period in aclk cycles and may stop the oscillator.
`default_nettype none
module scg_osc_model (
  input  wire logic       aclk,
  input  wire logic [7:0] half,
  input  wire logic       run,
  input  wire logic       loss,
  input  wire logic       pierce,
  output var  logic       raw_osc_clock,
  output var  logic       monitor_loss_flag,
  output var  logic       osc_type_select
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] cnt = 8'h00;
  logic       level = 1'b0;
  // A stopped oscillator freezes at its last level, as a dead crystal does.
  always @(posedge aclk) begin
    if (run) begin
      if (cnt + 8'h01 >= half) begin
        cnt <= 8'h00;
        level <= ~level;
      end else begin
        cnt <= cnt + 8'h01;
      end
    end
  end
  assign raw_osc_clock = level;
  assign monitor_loss_flag = loss;
  assign osc_type_select = pierce;
endmodule // scg_osc_model
`default_nettype wire

// ===== verif/system_clock_generator_bench.sv
// Self-checking bench for the system clock generator.
// Assumes the oscillator model as far side and a 200 MHz aclk.
`default_nettype none
module system_clock_generator_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        raw, mflag, strap, pierce_out, osc_tick, synth_tick, core_tick, bus_tick;
  logic [7:0]  half = 8'h0a;
  logic        run = 1'b1, loss = 1'b0, pierce = 1'b1;
  int          error_cnt = 0, check_count = 0, cyc = 0, gap = 0, mingap = 0;
  int          n_osc = 0, n_core = 0, n_bus = 0, n_syn = 0, m, r, a0, c0, b0, s0;
  logic [31:0] rq_d[$], rq_m[$];
  logic [1:0]  rq_r[$], bq[$];

  always #2.5 aclk = ~aclk;

  scg_system_clock_gen DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .raw_osc_clock(raw), .monitor_loss_flag(mflag), .osc_type_select(strap),
    .osc_mode_pierce(pierce_out), .osc_tick(osc_tick), .synth_tick(synth_tick),
    .core_tick(core_tick), .bus_tick(bus_tick));

  scg_osc_model osc (.aclk(aclk), .half(half), .run(run), .loss(loss), .pierce(pierce),
    .raw_osc_clock(raw), .monitor_loss_flag(mflag), .osc_type_select(strap));

  task automatic conclude();
    $display("Checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic near(input string what, input int exp, input int got, input int tol);
    check_count++;
    if (got < exp - tol || got > exp + tol) begin
      error_cnt++;
      $display("ERROR %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    bq.push_back(er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] mk,
                    input logic [1:0] er);
    rq_d.push_back(e);
    rq_m.push_back(mk);
    rq_r.push_back(er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask

  task automatic do_reset();
    mingap = 0;
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask

  task automatic window(input int w);
    a0 = n_osc;
    c0 = n_core;
    b0 = n_bus;
    s0 = n_syn;
    repeat (w) @(posedge aclk);
  endtask

  // Answers are matched to the oldest note, so reads and writes stay in issue order.
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      conclude();
    end
  end

  always @(posedge aclk) begin
    if (aresetn) begin
      if (bvalid && bready) cmp("bresp", {30'h0, bq.pop_front()}, {30'h0, bresp});
      if (rvalid && rready) begin
        cmp("rdata", rq_d.pop_front(), rdata & rq_m.pop_front());
        cmp("rresp", {30'h0, rq_r.pop_front()}, {30'h0, rresp});
      end
      if (osc_tick) n_osc++;
      if (synth_tick) n_syn++;
      if (bus_tick) n_bus++;
      if (bus_tick) cmp("bus_with_core", 32'h1, {31'h0, core_tick});
      if (core_tick && mingap > 0) cmp("core_gap_short", 32'h0, {31'h0, gap + 1 < mingap});
      if (core_tick) n_core++;
      gap = core_tick ? 0 : gap + 1;
    end
  end

  initial begin
    void'($urandom(32'h91bc));
    do_reset();
    cmp("pierce_mode", 32'h1, {31'h0, pierce_out});
    rd(scg_pkg::ADDR_MULT, 32'h0, 32'hffffffff, scg_pkg::RESP_OKAY);
    rd(scg_pkg::ADDR_REFDIV, 32'h0, 32'hffffffff, scg_pkg::RESP_OKAY);
    rd(scg_pkg::ADDR_CTRL, 32'h0, 32'hffffffff, scg_pkg::RESP_OKAY);
    rd(12'h0f0, 32'h0, 32'hffffffff, scg_pkg::RESP_SLVERR);
    repeat (100) @(posedge aclk);
    rd(scg_pkg::ADDR_PERIOD, 32'h14, 32'hffffffff, scg_pkg::RESP_OKAY);
    rd(scg_pkg::ADDR_STATUS, 32'h10, 32'h1d, scg_pkg::RESP_OKAY);
    window(800);
    near("osc_ticks", 40, n_osc - a0, 1);
    near("core_ticks_osc", n_osc - a0, n_core - c0, 1);
    near("bus_ticks_osc", (n_core - c0) / 2, n_bus - b0, 1);
    near("synth_off", 0, n_syn - s0, 0);
    m = $urandom % 5;
    r = $urandom % 4;
    wr(scg_pkg::ADDR_MULT, ($urandom << 6) | 32'(m), 4'h1, scg_pkg::RESP_OKAY);
    wr(scg_pkg::ADDR_MULT, 32'h3f, 4'he, scg_pkg::RESP_OKAY);
    wr(scg_pkg::ADDR_REFDIV, ($urandom << 4) | 32'(r), 4'hf, scg_pkg::RESP_OKAY);
    wr(12'h0f0, 32'h1, 4'hf, scg_pkg::RESP_SLVERR);
    rd(scg_pkg::ADDR_MULT, 32'(m), 32'hffffffff, scg_pkg::RESP_OKAY);
    rd(scg_pkg::ADDR_REFDIV, 32'(r), 32'hffffffff, scg_pkg::RESP_OKAY);
    // Synthesizer gaps jitter by a cycle, so one cycle of slack is allowed.
    mingap = (20 * (r + 1)) / (2 * (m + 1));
    mingap = (mingap < 20 ? mingap : 20) - 1;
    wr(scg_pkg::ADDR_CTRL, 32'h3, 4'hf, scg_pkg::RESP_OKAY);
    repeat (200) @(posedge aclk);
    rd(scg_pkg::ADDR_STATUS, 32'h1, 32'h21, scg_pkg::RESP_OKAY);
    window(800);
    near("synth_rate", (80 * (m + 1)) / (r + 1), n_syn - s0, 2);
    near("core_ticks_synth", n_syn - s0, n_core - c0, 1);
    near("bus_ticks_synth", (n_core - c0) / 2, n_bus - b0, 1);
    near("osc_ticks_synth", 40, n_osc - a0, 1);
    loss <= 1'b1;
    repeat (4) @(posedge aclk);
    loss <= 1'b0;
    rd(scg_pkg::ADDR_STATUS, 32'h2, 32'h2, scg_pkg::RESP_OKAY);
    rd(scg_pkg::ADDR_CTRL, 32'h3, 32'hffffffff, scg_pkg::RESP_OKAY);
    wr(scg_pkg::ADDR_STATUS, 32'h2, 4'h1, scg_pkg::RESP_OKAY);
    rd(scg_pkg::ADDR_STATUS, 32'h0, 32'h2, scg_pkg::RESP_OKAY);
    mingap = 0;
    run <= 1'b0;
    repeat (450) @(posedge aclk);
    rd(scg_pkg::ADDR_STATUS, 32'h4, 32'h4, scg_pkg::RESP_OKAY);
    rd(scg_pkg::ADDR_PERIOD, 32'h0, 32'hffffffff, scg_pkg::RESP_OKAY);
    window(200);
    near("synth_lost", 0, n_syn - s0, 0);
    rd(scg_pkg::ADDR_CTRL, 32'h3, 32'hffffffff, scg_pkg::RESP_OKAY);
    half <= 8'h01;
    run <= 1'b1;
    repeat (50) @(posedge aclk);
    rd(scg_pkg::ADDR_STATUS, 32'h8, 32'h8, scg_pkg::RESP_OKAY);
    pierce <= 1'b0;
    half <= 8'h0a;
    do_reset();
    cmp("colpitts_mode", 32'h0, {31'h0, pierce_out});
    rd(scg_pkg::ADDR_STATUS, 32'h0, 32'h11, scg_pkg::RESP_OKAY);
    rd(scg_pkg::ADDR_CTRL, 32'h0, 32'hffffffff, scg_pkg::RESP_OKAY);
    conclude();
  end
endmodule // system_clock_generator_bench
`default_nettype wire
